//--- smps_pkg.sv
// shared constants and types for the serial mac port select pair
package smps_pkg;

    // ------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------
    localparam logic       HWSW_HARDWARE   = 1'b1;
    localparam logic       PS_SERIAL       = 1'b1;
    localparam logic       SPEED_10M       = 1'b0;
    localparam logic       RATE_BIT_RESET  = 1'b0;

    // ------------------------------------------------------------
    // link timing
    // ------------------------------------------------------------
    localparam int         SYS_CLK_MHZ     = 100;
    localparam int         LINK_CLK_MHZ    = 10;
    localparam int         LINK_DIV        = SYS_CLK_MHZ / LINK_CLK_MHZ;
    localparam int         LINK_HALF       = LINK_DIV / 2;
    localparam logic [3:0] DIV_RESET       = 4'h0;
    localparam int         MII_NIB         = 4;
    localparam int         BUF_DEPTH       = 2;

    // transmit framer states, gray from idle through send to last
    typedef enum logic [1:0] {
        SMPS_TX_IDLE = 2'b00,
        SMPS_TX_SEND = 2'b01,
        SMPS_TX_LAST = 2'b11
    } smps_tx_e;

endpackage : smps_pkg

//--- smps_if.sv
// pin-level carrier between the phy side and the mac side
`timescale 1ns/1ps
interface smps_if;
    import smps_pkg::*;
    // remapped mii pins
    logic       col;
    logic       crs;
    logic       rx_clk;
    logic [3:0] rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       tx_clk;
    logic [3:0] txd;
    logic       tx_en;
    logic       tx_er;
    // management pins, data line resolved from both enables
    logic       mdc;
    logic       mdio_phy_o;
    logic       mdio_phy_oe;
    logic       mdio_sta_o;
    logic       mdio_sta_oe;
    logic       mdio;
    // speed select pin, output of the phy in software mode
    logic       speed_sel_phy_o;
    logic       speed_sel_phy_oe;
    logic       speed_sel_drv;
    logic       speed_select;

    assign mdio = mdio_phy_oe ? mdio_phy_o :
                  (mdio_sta_oe ? mdio_sta_o : 1'b1);
    assign speed_select = speed_sel_phy_oe ? speed_sel_phy_o
                                           : speed_sel_drv;

    modport phy (
        output col, crs, rx_clk, rxd, rx_dv, rx_er, tx_clk,
        output mdio_phy_o, mdio_phy_oe, speed_sel_phy_o, speed_sel_phy_oe,
        input  txd, tx_en, tx_er, mdc, mdio, speed_select
    );
    modport mac (
        input  col, crs, rx_clk, rxd, rx_dv, rx_er, tx_clk,
        input  mdio,
        output txd, tx_en, tx_er, mdc, mdio_sta_o, mdio_sta_oe,
        output speed_sel_drv
    );
endinterface : smps_if

//--- smps_phy.sv
// phy end: serial mode select, pin remap and serial data paths
`timescale 1ns/1ps

// Operation
// - hardware mode: serial when ps high, speed low
// - software mode: serial when ps high, bit zero
// - software mode: speed pin outputs rate bit
// - separate tx and rx paths at 10 MHz
// - eight serial signals on the link
// - serial mode remaps mii pins to serial roles
// - receive bit on lowest rx pin only
// - mac sends on lowest tx pin only
// - error pins unused in serial mode
// - management pins live in every mode
// - management: data line plus manager clock
module smps_phy (
    smps_if.phy         pins,
    input  wire logic   link_clk,
    input  wire logic   nrst,
    input  wire logic   hardware_software_select,
    input  wire logic   parallel_serial_select,
    input  wire logic   rate_bit,
    input  wire logic   mdio_out,
    input  wire logic   mdio_out_en,
    input  wire logic   media_collision,
    input  wire logic   media_carrier,
    input  wire logic   rx_in_valid,
    input  wire logic   rx_in_bit,
    output logic        rx_in_ready,
    output logic        serial_mode,
    output logic        tx_out_valid,
    output logic        tx_out_bit,
    output logic        mdc_seen,
    output logic        mdio_seen
);
    import smps_pkg::*;

    typedef struct packed {
        logic [1:0] hw_sync;
        logic [1:0] ps_sync;
        logic [1:0] sp_sync;
        logic [1:0] rt_sync;
        logic [1:0] mdc_sync;
        logic [1:0] mdio_sync;
        logic       serial;
        logic       rate;
        logic       hw;
        logic       col;
        logic       crs;
        logic       rx_dv;
        logic       rx_bit;
        logic       tx_v;
        logic       tx_b;
        logic       mdio_o;
        logic       mdio_oe;
        logic [BUF_DEPTH-1:0] buf_v;
        logic [BUF_DEPTH-1:0] buf_d;
    } smps_phy_s;

    smps_phy_s st_r;
    smps_phy_s st_nxt;

    // ------------------------------------------------------------
    // next state, all on the link clock
    // ------------------------------------------------------------
    // mode pins are asynchronous straps, so each passes two flops
    always_comb begin
        st_nxt            = st_r;
        st_nxt.hw_sync    = {st_r.hw_sync[0], hardware_software_select};
        st_nxt.ps_sync    = {st_r.ps_sync[0], parallel_serial_select};
        st_nxt.sp_sync    = {st_r.sp_sync[0], pins.speed_select};
        st_nxt.rt_sync    = {st_r.rt_sync[0], rate_bit};
        st_nxt.mdc_sync   = {st_r.mdc_sync[0], pins.mdc};
        st_nxt.mdio_sync  = {st_r.mdio_sync[0], pins.mdio};
        st_nxt.hw         = st_r.hw_sync[1];
        st_nxt.rate       = st_r.rt_sync[1];
        // speed pin is an input only in hardware mode
        if (st_r.hw_sync[1] == HWSW_HARDWARE) begin
            st_nxt.serial = (st_r.ps_sync[1] == PS_SERIAL) &&
                            (st_r.sp_sync[1] == SPEED_10M);
        end else begin
            st_nxt.serial = (st_r.ps_sync[1] == PS_SERIAL) &&
                            (st_r.rt_sync[1] == SPEED_10M);
        end
        // status lines follow the media whenever serial is active
        st_nxt.col        = st_r.serial & media_collision;
        st_nxt.crs        = st_r.serial & media_carrier;
        // two-entry receive buffer: pop head each cycle, push tail
        if (st_r.buf_v[0]) begin
            st_nxt.rx_dv  = st_r.serial;
            st_nxt.rx_bit = st_r.buf_d[0];
            st_nxt.buf_v  = {1'b0, st_r.buf_v[1]};
            st_nxt.buf_d  = {1'b0, st_r.buf_d[1]};
        end else begin
            st_nxt.rx_dv  = 1'b0;
            st_nxt.rx_bit = 1'b0;
        end
        if (rx_in_valid && !st_nxt.buf_v[1]) begin
            if (!st_nxt.buf_v[0]) begin
                st_nxt.buf_v[0] = 1'b1;
                st_nxt.buf_d[0] = rx_in_bit;
            end else begin
                st_nxt.buf_v[1] = 1'b1;
                st_nxt.buf_d[1] = rx_in_bit;
            end
        end
        // transmit: only the lowest data pin is read, upper ignored
        st_nxt.tx_v       = st_r.serial & pins.tx_en;
        st_nxt.tx_b       = st_r.serial & pins.tx_en & pins.txd[0];
        // management drive is independent of the interface mode
        st_nxt.mdio_o     = mdio_out;
        st_nxt.mdio_oe    = mdio_out_en;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            st_r      <= '0;
            st_r.rate <= RATE_BIT_RESET;
        end else begin
            st_r      <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // pin drive from registers
    // ------------------------------------------------------------
    // link clock is the device's own clock, so both paths share it
    assign pins.rx_clk  = link_clk;
    assign pins.tx_clk  = link_clk;
    assign pins.col     = st_r.col;
    assign pins.crs     = st_r.crs;
    assign pins.rx_dv   = st_r.rx_dv;
    // upper receive pins and error pin held low when serial
    assign pins.rxd     = {3'h0, st_r.rx_bit};
    assign pins.rx_er   = 1'b0;
    assign pins.mdio_phy_o  = st_r.mdio_o;
    assign pins.mdio_phy_oe = st_r.mdio_oe;
    assign pins.speed_sel_phy_o  = st_r.rate;
    assign pins.speed_sel_phy_oe = ~st_r.hw;
    assign rx_in_ready  = ~st_r.buf_v[1];
    assign serial_mode  = st_r.serial;
    assign tx_out_valid = st_r.tx_v;
    assign tx_out_bit   = st_r.tx_b;
    assign mdc_seen     = st_r.mdc_sync[1];
    assign mdio_seen    = st_r.mdio_sync[1];

endmodule : smps_phy

//--- smps_mac.sv
// mac end: serial transmitter and receiver toward the phy
`timescale 1ns/1ps
module smps_mac (
    smps_if.mac         pins,
    input  wire logic   clk_sys,
    input  wire logic   nrst,
    input  wire logic   tx_valid,
    input  wire logic   tx_bit,
    input  wire logic   tx_last,
    input  wire logic   mdc_drive,
    input  wire logic   mdio_drive,
    input  wire logic   mdio_drive_en,
    output logic        tx_ready,
    output logic        rx_valid,
    output logic        rx_bit,
    output logic        col_seen,
    output logic        crs_seen
);
    import smps_pkg::*;

    // data paths live on the link clock the phy sends out
    typedef struct packed {
        smps_tx_e   tx_state;
        logic       tx_busy;
        logic       tx_b;
        logic       rx_v;
        logic       rx_b;
    } smps_mac_link_s;

    // management and status on the system clock
    typedef struct packed {
        logic [1:0] col_sync;
        logic [1:0] crs_sync;
        logic       mdc;
        logic       mdio_o;
        logic       mdio_oe;
    } smps_mac_s;

    smps_mac_link_s lk_r;
    smps_mac_link_s lk_nxt;
    smps_mac_s      st_r;
    smps_mac_s      st_nxt;

    // ------------------------------------------------------------
    // link side next state
    // ------------------------------------------------------------
    // oversampling a link clock near the system rate loses edges,
    // so the bit logic is clocked by the link clock itself
    always_comb begin
        lk_nxt      = lk_r;
        lk_nxt.rx_v = pins.rx_dv;
        lk_nxt.rx_b = pins.rx_dv & pins.rxd[0];
        // one bit per link edge; frame held until the last bit
        case (lk_r.tx_state)
            SMPS_TX_IDLE: begin
                if (tx_valid) begin
                    lk_nxt.tx_busy  = 1'b1;
                    lk_nxt.tx_b     = tx_bit;
                    lk_nxt.tx_state = tx_last ? SMPS_TX_LAST
                                              : SMPS_TX_SEND;
                end
            end
            SMPS_TX_SEND: begin
                if (tx_valid) begin
                    lk_nxt.tx_b     = tx_bit;
                    lk_nxt.tx_state = tx_last ? SMPS_TX_LAST
                                              : SMPS_TX_SEND;
                end
            end
            SMPS_TX_LAST: begin
                lk_nxt.tx_busy  = 1'b0;
                lk_nxt.tx_b     = 1'b0;
                lk_nxt.tx_state = SMPS_TX_IDLE;
            end
            default: begin
                lk_nxt.tx_state = SMPS_TX_IDLE;
            end
        endcase
    end

    // receive and transmit clocks share one source at the phy
    always_ff @(posedge pins.tx_clk or negedge nrst) begin
        if (!nrst) begin
            lk_r          <= '0;
            lk_r.tx_state <= SMPS_TX_IDLE;
        end else begin
            lk_r          <= lk_nxt;
        end
    end

    // ------------------------------------------------------------
    // system side next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt          = st_r;
        st_nxt.col_sync = {st_r.col_sync[0], pins.col};
        st_nxt.crs_sync = {st_r.crs_sync[0], pins.crs};
        st_nxt.mdc      = mdc_drive;
        st_nxt.mdio_o   = mdio_drive;
        st_nxt.mdio_oe  = mdio_drive_en;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    assign pins.tx_en       = lk_r.tx_busy;
    assign pins.txd         = {3'h0, lk_r.tx_b};
    assign pins.tx_er       = 1'b0;
    assign pins.mdc         = st_r.mdc;
    assign pins.mdio_sta_o  = st_r.mdio_o;
    assign pins.mdio_sta_oe = st_r.mdio_oe;
    assign pins.speed_sel_drv = SPEED_10M;
    assign tx_ready = (lk_r.tx_state != SMPS_TX_LAST);
    assign rx_valid = lk_r.rx_v;
    assign rx_bit   = lk_r.rx_b;
    assign col_seen = st_r.col_sync[1];
    assign crs_seen = st_r.crs_sync[1];

endmodule : smps_mac

//--- smps_assertions.sv
// link pin checker for the serial mac port select pair
`timescale 1ns/1ps
module smps_assertions (
    input wire logic link_clk,
    input wire logic nrst,
    input wire logic hardware_software_select,
    input wire logic parallel_serial_select,
    input wire logic rate_bit,
    input wire logic rx_in_valid,
    input wire logic rx_in_ready,
    input wire logic rx_in_bit,
    input wire logic serial_mode,
    input wire logic tx_out_valid,
    input wire logic tx_out_bit,
    input wire logic mdc_seen,
    input wire logic speed_select,
    input wire logic speed_sel_phy_oe,
    input wire logic col,
    input wire logic crs,
    input wire logic [3:0] rxd,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic [3:0] txd,
    input wire logic tx_en,
    input wire logic mdc
);
    // ------------------------------------------------------------
    // checks on the link clock
    // ------------------------------------------------------------
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!nrst);
    // six edges cover two sync flops plus the mode register
    property p_hw_sel;
        (hardware_software_select && parallel_serial_select
         && !speed_select) [*6] |-> serial_mode;
    endproperty
    a_hw_sel: assert property (p_hw_sel) else $error("hw select");
    property p_sw_sel;
        (!hardware_software_select && parallel_serial_select
         && !rate_bit) [*6] |-> serial_mode;
    endproperty
    a_sw_sel: assert property (p_sw_sel) else $error("sw select");
    property p_spd_out;
        (!hardware_software_select && $stable(rate_bit)) [*6]
        |-> speed_sel_phy_oe && speed_select == rate_bit;
    endproperty
    a_spd_out: assert property (p_spd_out) else $error("speed pin");
    // one spare edge lets registered pins follow the mode flop
    property p_idle;
        !serial_mode [*2] |-> !rx_dv && !col && !crs;
    endproperty
    a_idle: assert property (p_idle) else $error("pins not idle");
    property p_rx_pins;
        serial_mode |-> rxd[3:1] == 3'h0 && !rx_er;
    endproperty
    a_rx_pins: assert property (p_rx_pins) else $error("rx pins");
    property p_rx_walk;
        (serial_mode && !rx_dv && !rx_in_valid) [*3] ##1
        (rx_in_valid && rx_in_ready) |-> ##2
        (rx_dv && rxd[0] == $past(rx_in_bit, 2));
    endproperty
    a_rx_walk: assert property (p_rx_walk) else $error("rx walk");
    property p_tx_copy;
        serial_mode && $past(serial_mode) |-> tx_out_valid == $past(tx_en)
        && (!tx_out_valid || tx_out_bit == $past(txd[0]));
    endproperty
    a_tx_copy: assert property (p_tx_copy) else $error("tx copy");
    property p_mdc_sync;
        $stable(mdc) [*3] |-> mdc_seen == mdc;
    endproperty
    a_mdc_sync: assert property (p_mdc_sync) else $error("mdc");
endmodule : smps_assertions

//--- serial_10m_mac_port_select_tb.sv
// self-checking bench for the serial mac port select pair
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin \
    mismatches++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module serial_10m_mac_port_select_tb;
    logic clk_sys, link_clk, nrst, hardware_software_select;
    logic parallel_serial_select, rate_bit, mdio_out, mdio_out_en;
    logic media_collision, media_carrier, rx_in_valid, rx_in_bit;
    logic rx_in_ready, serial_mode, tx_out_valid, tx_out_bit, mdc_seen;
    logic mdio_seen, tx_valid, tx_bit, tx_last, mdc_drive, mdio_drive;
    logic mdio_drive_en, tx_ready, rx_valid, rx_bit, col_seen, crs_seen;
    int mismatches = 0;
    int n_tests = 0;
    logic txq[$];
    logic rxq[$];
    smps_if pif();
    smps_phy u_smps_phy (.pins(pif), .link_clk, .nrst,
        .hardware_software_select, .parallel_serial_select, .rate_bit,
        .mdio_out, .mdio_out_en, .media_collision, .media_carrier,
        .rx_in_valid, .rx_in_bit, .rx_in_ready, .serial_mode,
        .tx_out_valid, .tx_out_bit, .mdc_seen, .mdio_seen);
    smps_mac u_smps_mac (.pins(pif), .clk_sys, .nrst, .tx_valid, .tx_bit,
        .tx_last, .mdc_drive, .mdio_drive, .mdio_drive_en, .tx_ready,
        .rx_valid, .rx_bit, .col_seen, .crs_seen);
    smps_assertions u_smps_assertions (.link_clk, .nrst,
        .hardware_software_select, .parallel_serial_select, .rate_bit,
        .rx_in_valid, .rx_in_ready, .rx_in_bit, .serial_mode,
        .tx_out_valid, .tx_out_bit, .mdc_seen, .col(pif.col),
        .speed_select(pif.speed_select), .crs(pif.crs),
        .speed_sel_phy_oe(pif.speed_sel_phy_oe), .rxd(pif.rxd),
        .rx_dv(pif.rx_dv), .rx_er(pif.rx_er), .txd(pif.txd),
        .tx_en(pif.tx_en), .mdc(pif.mdc));
    // two unrelated clocks, link offset so edges never meet
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    // collectors sample mid-cycle, after the design's updates land
    always @(negedge link_clk) if (tx_out_valid === 1'b1)
        txq.push_back(tx_out_bit);
    always @(negedge link_clk) if (rx_valid === 1'b1)
        rxq.push_back(rx_bit);
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic set_mode(input logic h, input logic p, input logic r);
        @(posedge link_clk);
        hardware_software_select <= h;
        parallel_serial_select <= p;
        rate_bit <= r;
        repeat (8) @(posedge link_clk);
        @(negedge clk_sys);
    endtask : set_mode
    task automatic t_mode();
        for (int i = 0; i < 8; i++) begin
            set_mode(i[2], i[1], i[0]);
            `CHK("mode", i[1] & (i[2] | ~i[0]), serial_mode)
            `CHK("spd_oe", ~i[2], pif.speed_sel_phy_oe)
            if (!i[2]) `CHK("spd", i[0], pif.speed_select)
        end
        $display("mode test done");
    endtask : t_mode
    task automatic t_tx(input logic [7:0] d);
        txq.delete();
        @(posedge link_clk);
        for (int i = 0; i < 8; i++) begin
            tx_valid <= 1'b1;
            tx_bit <= d[i];
            tx_last <= (i == 7);
            do @(negedge link_clk); while (tx_ready !== 1'b1);
            @(posedge link_clk);
        end
        tx_valid <= 1'b0;
        for (int k = 0; k < 60 && txq.size() < 8; k++) @(posedge link_clk);
        `CHK("tx_n", 8, txq.size())
        for (int i = 0; i < 8; i++) `CHK("tx", d[i], txq[i])
        $display("tx test done");
    endtask : t_tx
    task automatic t_rx(input logic [7:0] d);
        rxq.delete();
        @(posedge link_clk);
        for (int i = 0; i < 8; i++) begin
            rx_in_valid <= 1'b1;
            rx_in_bit <= d[i];
            do @(negedge link_clk); while (rx_in_ready !== 1'b1);
            @(posedge link_clk);
        end
        rx_in_valid <= 1'b0;
        for (int k = 0; k < 90 && rxq.size() < 8; k++) @(posedge clk_sys);
        `CHK("rx_n", 8, rxq.size())
        for (int i = 0; i < 8; i++) `CHK("rx", d[i], rxq[i])
        $display("rx test done");
    endtask : t_rx
    task automatic t_status();
        @(posedge link_clk);
        media_collision <= 1'b1;
        media_carrier <= 1'b1;
        set_mode(1'b0, 1'b1, 1'b0);
        `CHK("col", 1'b1, col_seen)
        `CHK("crs", 1'b1, crs_seen)
        set_mode(1'b0, 1'b0, 1'b0);
        `CHK("col_mii", 1'b0, col_seen)
        `CHK("crs_mii", 1'b0, crs_seen)
        media_collision <= 1'b0;
        media_carrier <= 1'b0;
        $display("status test done");
    endtask : t_status
    task automatic t_mgmt();
        for (int i = 0; i < 4; i++) begin
            set_mode(1'b0, i[1], 1'b0);
            @(posedge clk_sys);
            mdc_drive <= i[0];
            mdio_drive <= i[0];
            mdio_drive_en <= 1'b1;
            set_mode(1'b0, i[1], 1'b0);
            `CHK("mdc", i[0], mdc_seen)
            `CHK("mdio_sta", i[0], mdio_seen)
            mdio_drive_en <= 1'b0;
            mdio_out <= ~i[0];
            mdio_out_en <= 1'b1;
            set_mode(1'b0, i[1], 1'b0);
            `CHK("mdio_phy", ~i[0], mdio_seen)
            mdio_out_en <= 1'b0;
        end
        $display("mgmt test done");
    endtask : t_mgmt
    // main sequence
    initial begin
        nrst = 1'b0;
        {hardware_software_select, parallel_serial_select, rate_bit,
         mdio_out, mdio_out_en, media_collision, media_carrier,
         rx_in_valid, rx_in_bit, tx_valid, tx_bit, tx_last, mdc_drive,
         mdio_drive, mdio_drive_en} = 15'h0000;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        t_mode();
        t_tx(8'hB4);
        t_rx(8'h5C);
        t_status();
        t_mgmt();
        end_of_test();
    end
    // cuts a hang short, well past the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        end_of_test();
    end
endmodule : serial_10m_mac_port_select_tb
